// *** src/fss_slave_state_machine.sv ***
// Slave operating state machine with watchdog and parameter dictionary,
// reached over APB. Assumes APB master on sys_clk; inputs arrive from pins.
`timescale 1ns/1ps
`default_nettype none
`include "fss_params.svh"
module fss_slave_state_machine
  import fss_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] phys_in,
  output logic      [31:0] phys_out,
  output logic             nv_save,
  output logic             wd_expired
);

  // ===========================================================
  // Parameter dictionary storage
  // ===========================================================
  // Small on-chip store; entry chosen from low index bits XORed with low subindex bits, area nibble
  // folded so old and new channel areas hit the same word.
  logic [31:0] pdict_q [`FSS_PDICT_DEPTH];
  logic [31:0] pdict_d [`FSS_PDICT_DEPTH];
  logic [`FSS_PDICT_DEPTH-1:0] pdict_ro;

  fss_regs_t r_q;
  fss_regs_t r_d;

  logic                      apb_wr;
  logic                      apb_rd;
  logic [`FSS_PDICT_AW-1:0]  p_slot;
  logic                      p_area;
  logic [23:0]               tick_wide;
  logic [16:0]               tick_top;
  logic                      tick;
  logic                      wd_active;
  logic                      wd_fire;
  logic                      p_writable;
  logic                      outputs_live;
  logic                      pd_allowed;
  logic                      mbx_allowed;
  logic                      req_valid;
  fss_state_t                req_state;

  assign apb_wr = psel && penable && pwrite && !r_q.pready;
  assign apb_rd = psel && penable && !pwrite && !r_q.pready;
  // Mirror the two channel areas onto one storage word
  assign p_area = (r_q.p_index[15:12] == `FSS_AREA_OLD) ||
                  (r_q.p_index[15:12] == `FSS_AREA_NEW);
  assign p_slot = r_q.p_index[`FSS_PDICT_AW-1:0] ^ r_q.p_sub[`FSS_PDICT_AW-1:0];

  // Entries in the low half are fixed identity data, read only
  genvar gi;
  generate
    for (gi = 0; gi < `FSS_PDICT_DEPTH; gi++) begin : g_ro
      assign pdict_ro[gi] = (gi < (`FSS_PDICT_DEPTH / 2));
    end
  endgenerate

  // The mirrored channel areas stay writable wherever their slot lands;
  // any other index in the low half is refused.
  assign p_writable = !pdict_ro[p_slot] || p_area;

  // ===========================================================
  // Watchdog tick
  // ===========================================================
  // Tick length is counted in local 25 MHz periods scaled to sys_clk;
  // one local period is 1.6 sys periods, so the tick is rounded down to
  // whole sys cycles and runs up to one cycle short at small multipliers.
  // The product is formed 24 bits wide: at the largest multiplier it needs
  // 22 bits, and a narrower sum would wrap to a far shorter tick.
  assign tick_wide = (24'(r_q.wd_mult) + 24'(`FSS_WD_EXTRA)) * 24'(`FSS_SYS_CLK_MHZ)
                     / 24'(`FSS_LOCAL_CLK_MHZ);
  // Longest tick, about 105 thousand cycles, still fits the 17-bit counter
  assign tick_top  = tick_wide[16:0];
  // The divider free-runs, so the first tick after a feed comes early
  assign tick      = (r_q.tick_cnt >= tick_top - 17'h00001);

  // Count of zero switches monitoring off entirely
  assign wd_active = r_q.wd_en && (r_q.wd_count != 16'h0000);

  // Last tick of the monitoring period. A feed in the same cycle loses,
  // so an access that arrives once the period has run out cannot hide it.
  // The count is not restarted when a smaller period is written; a late
  // shortening therefore expires at the next tick.
  assign wd_fire = wd_active && !r_q.wd_expired && tick &&
                   (r_q.wd_cnt + 16'h0001 >= r_q.wd_count);

  // ===========================================================
  // Traffic permission by state
  // ===========================================================
  always_comb begin
    pd_allowed  = 1'b0;
    mbx_allowed = 1'b0;
    unique case (r_q.state)
      FSS_INIT: begin
        pd_allowed  = 1'b0;
        mbx_allowed = 1'b0;
      end
      FSS_CONFIGURING: begin
        pd_allowed  = 1'b0;
        mbx_allowed = 1'b1;
      end
      FSS_INPUTS_ONLY: begin
        pd_allowed  = 1'b1;
        mbx_allowed = 1'b1;
      end
      FSS_RUNNING: begin
        pd_allowed  = 1'b1;
        mbx_allowed = 1'b1;
      end
      FSS_FW_UPDATE: begin
        // Mailbox kind comes with the write itself, as bit 8 of the control word
        pd_allowed  = 1'b0;
        mbx_allowed = pwdata[`FSS_CTRL_MBX_FILE];
      end
      default: begin
        pd_allowed  = 1'b0;
        mbx_allowed = 1'b0;
      end
    endcase
  end

  // Running drives outputs; inputs-only drives them only with no watchdog
  assign outputs_live = (r_q.state == FSS_RUNNING) ||
                        ((r_q.state == FSS_INPUTS_ONLY) && !wd_active);

  assign req_state = fss_state_t'(pwdata[`FSS_CTRL_REQ_LSB +: 3]);
  assign req_valid = apb_wr && (paddr == `FSS_REG_CTRL) && pwdata[`FSS_CTRL_GO_BIT];

  // ===========================================================
  // Next state
  // ===========================================================
  always_comb begin
    r_d = r_q;
    pdict_d = pdict_q;
    r_d.pready  = 1'b0;
    r_d.pslverr = 1'b0;
    r_d.nv_save = 1'b0;

    // Input synchroniser; only the second stage feeds logic
    r_d.in_meta   = phys_in;
    r_d.in_stable = r_q.in_meta;

    // Watchdog base tick divider
    if (tick) begin
      r_d.tick_cnt = 17'h00000;
    end else begin
      r_d.tick_cnt = r_q.tick_cnt + 17'h00001;
    end

    // Monitoring period: count ticks up to programmed count
    if (wd_fire) begin
      r_d.wd_expired = 1'b1;
    end else if (wd_active && !r_q.wd_expired && tick) begin
      r_d.wd_cnt = r_q.wd_cnt + 16'h0001;
    end
    if (!wd_active) begin
      r_d.wd_expired = 1'b0;
      r_d.wd_cnt     = 16'h0000;
    end

    // Inputs copied cyclically only in inputs-only and running states
    if ((r_q.state == FSS_INPUTS_ONLY) || (r_q.state == FSS_RUNNING)) begin
      r_d.in_dpram = r_q.in_stable;
    end

    // Physical outputs; expiry forces false without touching state.
    // Outputs follow the buffer one cycle late, so a new output word shows
    // on the pins the cycle after the transfer is answered.
    if (outputs_live && !r_q.wd_expired) begin
      r_d.phys_out = r_q.out_buf;
    end else begin
      r_d.phys_out = 32'h00000000;
    end

    // -------- APB access: one wait state on every transfer --------
    // The answer is registered, so pready rises the cycle after the access
    // phase is taken; the master still holds the request at that edge.
    if (psel && penable && !r_q.pready) begin
      r_d.pready = 1'b1;
      r_d.prdata = 32'h00000000;
    end

    if (apb_wr) begin
      unique case (paddr)
        `FSS_REG_CTRL: begin
          r_d.wd_en = pwdata[`FSS_CTRL_WDEN_BIT];
          // A process-data access is a cyclic exchange from the link
          if (pwdata[`FSS_CTRL_PDACC]) begin
            if (pd_allowed) begin
              // Expiry raised by this very cycle's tick stands until the next feed
              r_d.wd_cnt     = 16'h0000;
              r_d.wd_expired = wd_fire;
            end else begin
              r_d.pslverr = 1'b1;
            end
          end
          if (pwdata[`FSS_CTRL_MBX] && !mbx_allowed) begin
            r_d.pslverr = 1'b1;
          end
        end
        `FSS_REG_WDMULT:  r_d.wd_mult  = pwdata[15:0];
        `FSS_REG_WDCOUNT: r_d.wd_count = pwdata[15:0];
        `FSS_REG_PINDEX: begin
          r_d.p_index = pwdata[15:0];
          r_d.p_sub   = pwdata[23:16];
        end
        `FSS_REG_PDATA: begin
          if (r_q.p_index == `FSS_SUPPRESS_IDX) begin
            r_d.suppress_word = pwdata;
            r_d.save_suppress = (pwdata == `FSS_SUPPRESS_WORD);
          end else if (!p_writable) begin
            r_d.p_denied = 1'b1;
            r_d.pslverr  = 1'b1;
          end else begin
            pdict_d[p_slot] = pwdata;
            r_d.p_denied    = 1'b0;
            // Fail-safe store is done by the nonvolatile controller on this pulse
            r_d.nv_save = !r_q.save_suppress;
          end
        end
        `FSS_REG_OUTDATA: begin
          if (pd_allowed) begin
            r_d.out_buf = pwdata;
          end else begin
            r_d.pslverr = 1'b1;
          end
        end
        `FSS_REG_CHECKS: begin
          r_d.mbx_ok = pwdata[0];
          r_d.pd_ok  = pwdata[1];
        end
        default: r_d.pslverr = 1'b1;
      endcase
    end

    if (apb_rd) begin
      unique case (paddr)
        `FSS_REG_CTRL:    r_d.prdata = {26'h0, r_q.wd_en, 2'h0, 3'(r_q.state)};
        `FSS_REG_STATUS:  r_d.prdata = {25'h0, r_q.nv_save, r_q.save_suppress,
                                         r_q.p_denied, r_q.req_refused, r_q.wd_expired,
                                         r_q.mbx_ok, r_q.pd_ok};
        `FSS_REG_WDMULT:  r_d.prdata = {16'h0, r_q.wd_mult};
        `FSS_REG_WDCOUNT: r_d.prdata = {16'h0, r_q.wd_count};
        `FSS_REG_PINDEX:  r_d.prdata = {8'h0, r_q.p_sub, r_q.p_index};
        `FSS_REG_PDATA: begin
          if (r_q.p_index == `FSS_SUPPRESS_IDX) begin
            r_d.prdata = r_q.suppress_word;
          end else begin
            r_d.prdata = pdict_q[p_slot];
          end
        end
        // Every slot is readable; rw repeats the writable bit
        `FSS_REG_PACCESS: r_d.prdata = {29'h0, p_writable, 1'b1, p_writable};
        `FSS_REG_OUTDATA: r_d.prdata = r_q.out_buf;
        `FSS_REG_INDATA:  r_d.prdata = r_q.in_dpram;
        `FSS_REG_CHECKS:  r_d.prdata = {30'h0, r_q.pd_ok, r_q.mbx_ok};
        default:          r_d.pslverr = 1'b1;
      endcase
    end

    // -------- State requests --------
    // A request is refused unless its branch below accepts it; the refusal
    // flag then stands until the next request, so software may read it late.
    // Falling back to init is always allowed, as the master's recovery path.
    if (req_valid) begin
      r_d.req_refused = 1'b1;
      unique case (req_state)
        FSS_INIT: begin
          r_d.state       = FSS_INIT;
          r_d.req_refused = 1'b0;
        end
        FSS_CONFIGURING: begin
          if ((r_q.state == FSS_INIT) && r_q.mbx_ok) begin
            r_d.state       = FSS_CONFIGURING;
            r_d.req_refused = 1'b0;
          end else if (r_q.state != FSS_INIT && r_q.state != FSS_FW_UPDATE) begin
            r_d.state       = FSS_CONFIGURING;
            r_d.req_refused = 1'b0;
          end
        end
        FSS_INPUTS_ONLY: begin
          if ((r_q.state == FSS_CONFIGURING) && r_q.pd_ok) begin
            r_d.in_dpram    = r_q.in_stable;
            r_d.state       = FSS_INPUTS_ONLY;
            r_d.req_refused = 1'b0;
          end else if (r_q.state == FSS_RUNNING) begin
            r_d.state       = FSS_INPUTS_ONLY;
            r_d.req_refused = 1'b0;
          end
        end
        FSS_RUNNING: begin
          if (r_q.state == FSS_INPUTS_ONLY) begin
            r_d.state       = FSS_RUNNING;
            r_d.req_refused = 1'b0;
          end
        end
        FSS_FW_UPDATE: begin
          if (r_q.state == FSS_INIT) begin
            r_d.state       = FSS_FW_UPDATE;
            r_d.req_refused = 1'b0;
          end
        end
        default: r_d.req_refused = 1'b1;
      endcase
    end
  end

  // ===========================================================
  // Registers
  // ===========================================================
  // The dictionary store is volatile and clears with the rest; keeping a
  // value across power cycles is the job of the nonvolatile controller
  // that answers the save pulse.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r_q               <= '0;
      r_q.state         <= FSS_INIT;
      r_q.wd_mult       <= `FSS_WDMULT_RST;
      r_q.wd_count      <= `FSS_WDCOUNT_RST;
      r_q.wd_en         <= 1'b1;
      r_q.save_suppress <= 1'b0;
      for (int i = 0; i < `FSS_PDICT_DEPTH; i++) begin
        pdict_q[i] <= 32'h00000000;
      end
    end else begin
      r_q <= r_d;
      for (int i = 0; i < `FSS_PDICT_DEPTH; i++) begin
        pdict_q[i] <= pdict_d[i];
      end
    end
  end

  assign prdata     = r_q.prdata;
  assign pready     = r_q.pready;
  assign pslverr    = r_q.pslverr;
  assign phys_out   = r_q.phys_out;
  assign nv_save    = r_q.nv_save;
  assign wd_expired = r_q.wd_expired;

endmodule
`default_nettype wire

// *** src/fss_params.svh ***
// Constants for the fieldbus slave state machine block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef FSS_PARAMS_SVH
`define FSS_PARAMS_SVH

// Register byte offsets
`define FSS_REG_CTRL      12'h000
`define FSS_REG_STATUS    12'h004
`define FSS_REG_WDMULT    12'h008
`define FSS_REG_WDCOUNT   12'h00c
`define FSS_REG_PINDEX    12'h010
`define FSS_REG_PDATA     12'h014
`define FSS_REG_PACCESS   12'h018
`define FSS_REG_OUTDATA   12'h01c
`define FSS_REG_INDATA    12'h020
`define FSS_REG_CHECKS    12'h024

// Reset values
`define FSS_WDMULT_RST    16'h09c2
`define FSS_WDCOUNT_RST   16'h03e8

// Watchdog tick: multiplier plus this many base clocks
`define FSS_WD_EXTRA      17'h00002
`define FSS_LOCAL_CLK_MHZ 25
`define FSS_SYS_CLK_MHZ   40

// Parameter dictionary
`define FSS_SUPPRESS_IDX  16'hf008
`define FSS_SUPPRESS_WORD 32'h12345678
`define FSS_AREA_OLD      4'h4
`define FSS_AREA_NEW      4'h8
`define FSS_PDICT_DEPTH   16
`define FSS_PDICT_AW      4

// Control register fields
`define FSS_CTRL_REQ_LSB  0
`define FSS_CTRL_GO_BIT   4
`define FSS_CTRL_WDEN_BIT 5
`define FSS_CTRL_PDACC    6
`define FSS_CTRL_MBX      7
`define FSS_CTRL_MBX_FILE 8

// Parameter access register fields
`define FSS_PACC_WR_BIT   0
`define FSS_PACC_RD_BIT   1
`define FSS_PACC_RW_BIT   2

`endif

// *** src/fss_pkg.sv ***
// Types for the fieldbus slave state machine block.
// Assumes fss_params.svh is on the include path.
`include "fss_params.svh"
package fss_pkg;

  // Gray codes along init, configuring, inputs only, running
  typedef enum logic [2:0] {
    FSS_INIT       = 3'h0,
    FSS_CONFIGURING= 3'h1,
    FSS_INPUTS_ONLY= 3'h3,
    FSS_RUNNING    = 3'h2,
    FSS_FW_UPDATE  = 3'h6
  } fss_state_t;

  typedef struct packed {
    fss_state_t  state;
    logic [15:0] wd_mult;
    logic [15:0] wd_count;
    logic        wd_en;
    logic [16:0] tick_cnt;
    logic [15:0] wd_cnt;
    logic        wd_expired;
    logic        req_refused;
    logic [15:0] p_index;
    logic [7:0]  p_sub;
    logic [31:0] p_wdata;
    logic [31:0] p_rdata;
    logic        p_denied;
    logic        save_suppress;
    logic        nv_save;
    logic [31:0] suppress_word;
    logic [31:0] out_buf;
    logic [31:0] phys_out;
    logic [31:0] in_dpram;
    logic [2:0]  in_sync;
    logic [31:0] in_meta;
    logic [31:0] in_stable;
    logic        mbx_ok;
    logic        pd_ok;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fss_regs_t;

endpackage

// *** verif/fss_slave_state_machine_checker.sv ***
// Concurrent checks on the slave state machine ports.
// Assumes one clock, sys_clk, and the active-low reset rstn.
`timescale 1ns/1ps
`default_nettype none
module fss_slave_state_machine_checker (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] phys_out,
  input wire logic        nv_save,
  input wire logic        wd_expired
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========
  // Bus answer
  a_ready_after: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered next cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  a_ready_quiet: assert property (!(psel && penable) |=> !pready)
    else $error("answer without an access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("refusal outside an answer");
  // ==========
  // Saving and watchdog
  a_save_pulse: assert property (nv_save |=> !nv_save)
    else $error("save request longer than one cycle");
  a_save_cause: assert property (nv_save |-> $past(psel && pwrite))
    else $error("save request without a write");
  a_expired_holds: assert property (wd_expired && !psel |=> wd_expired)
    else $error("expiry cleared without an access");
  a_out_zero: assert property (wd_expired [*2] |-> phys_out == 32'h0)
    else $error("outputs driven after expiry");
  a_out_cause: assert property ($changed(phys_out) |->
    $past(psel) || $past(psel, 2) || wd_expired || $past(wd_expired) ||
    $past(wd_expired, 2))
    else $error("outputs changed without cause");
  c_save: cover property (nv_save);
  c_expire: cover property ($rose(wd_expired));
  c_refuse: cover property (pslverr);
endmodule
bind fss_slave_state_machine fss_slave_state_machine_checker i_fss_slave_state_machine_checker (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .phys_out(phys_out), .nv_save(nv_save),
  .wd_expired(wd_expired));
`default_nettype wire

// *** verif/fss_master_model.sv ***
// Fieldbus master model: APB transfers and the master's duties.
// Assumes the slave answers with pready; signals change after rising edges.
`timescale 1ns/1ps
`default_nettype none
`include "fss_params.svh"
module fss_master_model (
  input  wire logic        sys_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rd_data;
  logic        rd_err;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // ==========
  // One transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait for the answer however long it takes; the bench's watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========
  // Master duties
  task automatic setup_mailbox();
    xfer(1'b1, `FSS_REG_CHECKS, 32'h1);
  endtask
  task automatic setup_pd();
    xfer(1'b1, `FSS_REG_CHECKS, 32'h3);
  endtask
  task automatic send_outputs(input logic [31:0] d);
    xfer(1'b1, `FSS_REG_OUTDATA, d);
  endtask
  // Watchdog enable kept set with every request
  task automatic request(input logic [2:0] st);
    xfer(1'b1, `FSS_REG_CTRL, {24'h0, 8'h30} | {29'h0, st});
  endtask
endmodule
`default_nettype wire

// *** verif/fss_slave_state_machine_bench.sv ***
// Self-checking bench for the slave state machine.
// Assumes the master model drives APB; the bench drives pins and reset.
`timescale 1ns/1ps
`default_nettype none
`include "fss_params.svh"
module fss_slave_state_machine_bench;
  logic        sys_clk = 1'b0;
  logic        rstn;
  logic        psel, penable, pwrite, pready, pslverr, nv_save, wd_expired;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, phys_out;
  logic [31:0] phys_in;
  int          num_errors, samples_checked, saves, s0, n;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (nv_save === 1'b1) saves <= saves + 1;
  fss_slave_state_machine i_fss_slave_state_machine (.sys_clk(sys_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phys_in(phys_in),
    .phys_out(phys_out), .nv_save(nv_save), .wd_expired(wd_expired));
  fss_master_model i_fss_master_model (.sys_clk(sys_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ==========
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_fss_master_model.xfer(1'b1, a, d);
  endtask
  task automatic rd(input string w, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    i_fss_master_model.xfer(1'b0, a, 32'h0);
    check(w, i_fss_master_model.rd_data & m, e);
  endtask
  task automatic err(input string w, input logic e);
    check(w, {31'h0, i_fss_master_model.rd_err}, {31'h0, e});
  endtask
  task automatic state(input string w, input logic [2:0] e);
    rd(w, `FSS_REG_CTRL, 32'h7, {29'h0, e});
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
  // ==========
  // Tests
  initial begin
    rstn <= 1'b0;
    phys_in <= 32'hcafe0001;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    rd("mult reset", `FSS_REG_WDMULT, 32'hffff, 32'h09c2);
    rd("count reset", `FSS_REG_WDCOUNT, 32'hffff, 32'h03e8);
    state("state after reset", 3'h0);
    wr(`FSS_REG_CTRL, 32'ha0);
    err("mailbox in init", 1'b1);
    wr(`FSS_REG_CTRL, 32'h60);
    err("pd in init", 1'b1);
    i_fss_master_model.request(3'h1);
    state("config without mailbox", 3'h0);
    rd("refused flag", `FSS_REG_STATUS, 32'h8, 32'h8);
    i_fss_master_model.setup_mailbox();
    i_fss_master_model.request(3'h1);
    state("config", 3'h1);
    wr(`FSS_REG_CTRL, 32'ha1);
    err("mailbox in config", 1'b0);
    wr(`FSS_REG_CTRL, 32'h61);
    err("pd in config", 1'b1);
    i_fss_master_model.request(3'h6);
    state("update from config", 3'h1);
    i_fss_master_model.setup_pd();
    i_fss_master_model.request(3'h3);
    state("inputs only", 3'h3);
    rd("inputs copied", `FSS_REG_INDATA, 32'hffffffff, 32'hcafe0001);
    phys_in <= 32'h0000beef;
    repeat (4) @(posedge sys_clk);
    rd("inputs updated", `FSS_REG_INDATA, 32'hffffffff, 32'h0000beef);
    wr(`FSS_REG_CTRL, 32'h63);
    err("pd in inputs only", 1'b0);
    i_fss_master_model.send_outputs(32'h5a5a00ff);
    check("outputs safe", phys_out, 32'h0);
    i_fss_master_model.request(3'h2);
    repeat (2) @(posedge sys_clk);
    check("outputs running", phys_out, 32'h5a5a00ff);
    // Tick of 3 cycles at multiplier 0, period of 12 cycles at count 4
    wr(`FSS_REG_WDMULT, 32'h0);
    wr(`FSS_REG_WDCOUNT, 32'h4);
    for (int i = 0; i < 6; i++) wr(`FSS_REG_CTRL, 32'h62);
    check("no expiry while fed", {31'h0, wd_expired}, 32'h0);
    n = 0;
    while (wd_expired !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    check("expiry delay", {31'h0, n >= 8 && n <= 24}, 32'h1);
    // Outputs fall one cycle after the expiry flag rises
    @(posedge sys_clk);
    check("outputs after expiry", phys_out, 32'h0);
    state("state after expiry", 3'h2);
    wr(`FSS_REG_WDCOUNT, 32'h0);
    wr(`FSS_REG_CTRL, 32'h62);
    i_fss_master_model.request(3'h3);
    repeat (100) @(posedge sys_clk);
    check("watchdog off", {31'h0, wd_expired}, 32'h0);
    check("outputs without watchdog", phys_out, 32'h5a5a00ff);
    wr(`FSS_REG_PINDEX, 32'h00008001);
    s0 = saves;
    wr(`FSS_REG_PDATA, 32'h11112222);
    repeat (2) @(posedge sys_clk);
    check("save pulses", saves - s0, 32'h1);
    wr(`FSS_REG_PINDEX, 32'h00004001);
    rd("mirror", `FSS_REG_PDATA, 32'hffffffff, 32'h11112222);
    wr(`FSS_REG_PINDEX, 32'h00ff8000);
    wr(`FSS_REG_PDATA, 32'h33334444);
    rd("full subindex", `FSS_REG_PDATA, 32'hffffffff, 32'h33334444);
    wr(`FSS_REG_PINDEX, 32'h00001003);
    wr(`FSS_REG_PDATA, 32'h1);
    err("read-only write", 1'b1);
    rd("access attribute", `FSS_REG_PACCESS, 32'h7, 32'h2);
    wr(`FSS_REG_PINDEX, {16'h0, `FSS_SUPPRESS_IDX});
    wr(`FSS_REG_PDATA, `FSS_SUPPRESS_WORD);
    s0 = saves;
    wr(`FSS_REG_PINDEX, 32'h00008001);
    wr(`FSS_REG_PDATA, 32'h5555);
    repeat (2) @(posedge sys_clk);
    check("suppressed saves", saves - s0, 32'h0);
    rd("suppress flag", `FSS_REG_STATUS, 32'h20, 32'h20);
    i_fss_master_model.xfer(1'b0, 12'h040, 32'h0);
    err("unmapped", 1'b1);
    rstn <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    rd("suppress after reset", `FSS_REG_STATUS, 32'h20, 32'h0);
    i_fss_master_model.request(3'h6);
    state("update from init", 3'h6);
    wr(`FSS_REG_CTRL, 32'h1a0);
    err("file mailbox in update", 1'b0);
    wr(`FSS_REG_CTRL, 32'ha0);
    err("other mailbox in update", 1'b1);
    wr(`FSS_REG_CTRL, 32'h60);
    err("pd in update", 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
